// >>> verilog/temp_monitor_pkg.sv
// shared constants and types for the temperature monitor serial slave
package temp_monitor_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYCLES = GLITCH_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // bus addresses
   // ----------------------------------------
   localparam logic [3:0] SENSOR_ADDR_HI = 4'h9;
   localparam logic [3:0] EEPROM_ADDR_HI = 4'ha;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   // ----------------------------------------
   // register pointers and config fields
   // ----------------------------------------
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_TLOW = 2'h2;
   localparam logic [1:0] PTR_THIGH = 2'h3;
   localparam int CFG_SD = 0;
   localparam int CFG_COMPARATOR_INTERRUPT_SELECT = 1;
   localparam int CFG_POL = 2;
   localparam int CFG_FT_LSB = 3;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [15:0] TLOW_RESET = 16'h4b00;
   localparam logic [15:0] THIGH_RESET = 16'h5000;
   localparam int EEPROM_DEPTH = 256;
   localparam int EEPROM_AW = 8;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} bus_state_type;
   typedef enum logic [1:0] {TGT_SENSOR, TGT_EEPROM, TGT_ARA} target_type;
endpackage

// >>> verilog/line_filter.sv
// two-flop synchroniser and glitch filter for the serial clock and data lines
`timescale 1ns/1ps
module line_filter
   import temp_monitor_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // raw and filtered lines
   input wire logic [1:0] line_i,
   output logic [1:0] line_o
);
   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bit
         logic meta;
         logic sync;
         logic [7:0] cnt;
         // idle bus lines are high, so reset to one
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta <= 1'b1;
               sync <= 1'b1;
            end else begin
               meta <= line_i[b];
               sync <= meta;
            end
         end
         // a level must hold for the whole spike window before it is believed
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cnt <= 8'h00;
               line_o[b] <= 1'b1;
            end else if (sync == line_o[b]) begin
               cnt <= 8'h00;
            end else if (cnt == 8'(GLITCH_CYCLES - 1)) begin
               cnt <= 8'h00;
               line_o[b] <= sync;
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   endgenerate
endmodule

// >>> verilog/temp_monitor_alert.sv
// temperature monitor: two-wire slave, limit registers, alarm output, eeprom
// Function
// - sample data on scl rise, change own sda output only after scl fall
// - sda is only pulled low or released, never driven high
// - alarm condition sets when temperature rises above the high limit, clears only below the low limit
// - alarm runs in comparator or interrupt mode chosen by a config bit
// - alarm is active low when polarity bit clear, active high when set; after reset the bit comes from the stored config
// - alarm trips only after the configured count of consecutive faults
// - shutdown stops conversion but keeps the serial interface working
// - a stored config can start the device in shutdown at power-up
// - config and limits are restored from nonvolatile copies after reset
// - latest result sits in a register readable at any time
// - result register spans the full -55 to +125 degree range
// - an eeprom array is reachable over the same two-wire bus
// - alert response address read is answered by the alerting device
// - low three address bits are compared with the address select pins
// - bytes go msb first, receiver answers ack or nack on ninth clock
// - writes to the read-only temperature register are refused with nack
`timescale 1ns/1ps
module temp_monitor_alert
   import temp_monitor_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial bus, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] address_select_pins_i,
   // alarm, open drain
   output logic alert_o,
   output logic alert_oe_o,
   // converter
   input wire logic [11:0] temp_sample_i,
   input wire logic temp_valid_i,
   output logic conv_en_o,
   // nonvolatile copies
   input wire logic [7:0] nv_config_i,
   input wire logic [15:0] nv_tlow_i,
   input wire logic [15:0] nv_thigh_i
);
   logic [1:0] filt;
   logic scl_f, sda_f, scl_prev, sda_prev;
   logic scl_rise, scl_fall, start_evt, stop_evt;
   bus_state_type state;
   target_type target;
   logic first, rw, host_ack, loaded;
   logic [3:0] bitcnt;
   logic [7:0] shift, txsh, tx_byte;
   logic [7:0] cfg, msb_hold;
   logic [15:0] tlow, thigh;
   logic [11:0] temp;
   logic [1:0] pointer;
   logic [EEPROM_AW-1:0] eaddr;
   logic [7:0] byte_idx;
   logic [7:0] mem [EEPROM_DEPTH];
   logic rx_done, tx_load, addr_hit, ro_nack, conv_ok, over, under;
   logic alarm_cond, int_latch, alert_act, int_clear;
   logic [2:0] fault_cnt, fault_need;

   // ----------------------------------------
   // line conditioning and bus events
   // ----------------------------------------
   line_filter line_filter_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .line_i({scl_i, sda_i}),
      .line_o(filt)
   );
   assign scl_f = filt[1];
   assign sda_f = filt[0];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end
   assign scl_rise = scl_f && !scl_prev;
   assign scl_fall = !scl_f && scl_prev;
   assign start_evt = scl_f && scl_prev && sda_prev && !sda_f;
   assign stop_evt = scl_f && scl_prev && !sda_prev && sda_f;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign rx_done = scl_fall && state == ST_RX && bitcnt == 4'h8;
   assign tx_load = scl_fall && ((state == ST_RX_ACK && rw) || (state == ST_TX_ACK && host_ack));
   assign addr_hit = shift[7:1] == {SENSOR_ADDR_HI, address_select_pins_i}
      || shift[7:1] == {EEPROM_ADDR_HI, address_select_pins_i}
      || (shift[7:1] == ALERT_RESP_ADDR && shift[0] && alert_act);
   assign ro_nack = target == TGT_SENSOR && byte_idx != 8'h00 && pointer == PTR_TEMP;
   always_comb begin
      tx_byte = cfg;
      if (target == TGT_EEPROM) begin
         tx_byte = mem[eaddr];
      end else if (target == TGT_ARA) begin
         tx_byte = {SENSOR_ADDR_HI, address_select_pins_i, 1'b0};
      end else begin
         case (pointer)
            PTR_TEMP: tx_byte = byte_idx[0] ? {temp[3:0], 4'h0} : temp[11:4];
            PTR_TLOW: tx_byte = byte_idx[0] ? tlow[7:0] : tlow[15:8];
            PTR_THIGH: tx_byte = byte_idx[0] ? thigh[7:0] : thigh[15:8];
            default: tx_byte = cfg;
         endcase
      end
   end

   // ----------------------------------------
   // bus state machine
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         target <= TGT_SENSOR;
         first <= 1'b0;
         rw <= 1'b0;
         host_ack <= 1'b0;
         bitcnt <= 4'h0;
         shift <= 8'h00;
         txsh <= 8'h00;
         sda_oe_o <= 1'b0;
      end else if (start_evt) begin
         state <= ST_RX;
         first <= 1'b1;
         bitcnt <= 4'h0;
         sda_oe_o <= 1'b0;
      end else if (stop_evt) begin
         state <= ST_IDLE;
         sda_oe_o <= 1'b0;
      end else begin
         case (state)
            ST_RX: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_f};
                  bitcnt <= bitcnt + 4'h1;
               end else if (rx_done) begin
                  bitcnt <= 4'h0;
                  first <= 1'b0;
                  if (!first) begin
                     sda_oe_o <= !ro_nack;
                     state <= ST_RX_ACK;
                  end else if (addr_hit) begin
                     rw <= shift[0];
                     if (shift[7:4] == EEPROM_ADDR_HI) begin
                        target <= TGT_EEPROM;
                     end else if (shift[7:1] == ALERT_RESP_ADDR) begin
                        target <= TGT_ARA;
                     end else begin
                        target <= TGT_SENSOR;
                     end
                     sda_oe_o <= 1'b1;
                     state <= ST_RX_ACK;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  if (rw) begin
                     txsh <= tx_byte;
                     sda_oe_o <= !tx_byte[7];
                     state <= ST_TX;
                  end else begin
                     sda_oe_o <= 1'b0;
                     state <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     state <= ST_TX_ACK;
                  end else begin
                     txsh <= {txsh[6:0], 1'b0};
                     sda_oe_o <= !txsh[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  host_ack <= !sda_f;
               end else if (scl_fall) begin
                  bitcnt <= 4'h0;
                  if (host_ack) begin
                     txsh <= tx_byte;
                     sda_oe_o <= !tx_byte[7];
                     state <= ST_TX;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // open drain: the data level is only ever low
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_o <= 1'b0;
         alert_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         alert_o <= 1'b0;
      end
   end

   // ----------------------------------------
   // register file, nonvolatile restore, eeprom pointer
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loaded <= 1'b0;
         cfg <= CONFIG_RESET;
         tlow <= TLOW_RESET;
         thigh <= THIGH_RESET;
         pointer <= PTR_TEMP;
         eaddr <= '0;
         byte_idx <= 8'h00;
         msb_hold <= 8'h00;
      end else if (!loaded) begin
         // straps cannot be caught under async reset, so restore on first edge
         loaded <= 1'b1;
         cfg <= nv_config_i;
         tlow <= nv_tlow_i;
         thigh <= nv_thigh_i;
      end else if (start_evt) begin
         byte_idx <= 8'h00;
      end else if (rx_done && !first) begin
         byte_idx <= byte_idx + 8'h01;
         if (target == TGT_EEPROM) begin
            eaddr <= (byte_idx == 8'h00) ? shift : eaddr + 8'h01;
         end else if (byte_idx == 8'h00) begin
            pointer <= shift[1:0];
         end else if (byte_idx == 8'h01) begin
            msb_hold <= shift;
            if (pointer == PTR_CONFIG) begin
               cfg <= shift;
            end
         end else if (byte_idx == 8'h02) begin
            if (pointer == PTR_TLOW) begin
               tlow <= {msb_hold, shift};
            end else if (pointer == PTR_THIGH) begin
               thigh <= {msb_hold, shift};
            end
         end
      end else if (tx_load) begin
         byte_idx <= byte_idx + 8'h01;
         if (target == TGT_EEPROM) begin
            eaddr <= eaddr + 8'h01;
         end
      end
   end
   // memory array keeps no reset
   always_ff @(posedge clk_i) begin
      if (rx_done && !first && target == TGT_EEPROM && byte_idx != 8'h00) begin
         mem[eaddr] <= shift;
      end
   end

   // ----------------------------------------
   // conversion and alarm
   // ----------------------------------------
   assign conv_ok = loaded && temp_valid_i && !cfg[CFG_SD];
   assign over = $signed(temp_sample_i) > $signed(thigh[15:4]);
   assign under = $signed(temp_sample_i) < $signed(tlow[15:4]);
   assign alert_act = cfg[CFG_COMPARATOR_INTERRUPT_SELECT] ? int_latch : alarm_cond;
   assign int_clear = tx_load && target != TGT_EEPROM;
   always_comb begin
      case (cfg[CFG_FT_LSB +: 2])
         2'h0: fault_need = 3'h1;
         2'h1: fault_need = 3'h2;
         2'h2: fault_need = 3'h4;
         default: fault_need = 3'h6;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         temp <= 12'h000;
         conv_en_o <= 1'b0;
      end else begin
         conv_en_o <= loaded && !cfg[CFG_SD];
         if (conv_ok) begin
            temp <= temp_sample_i;
         end
      end
   end
   // a trip needs fault_need consecutive samples beyond the limit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_cond <= 1'b0;
         fault_cnt <= 3'h0;
         int_latch <= 1'b0;
         alert_oe_o <= 1'b0;
      end else begin
         if (conv_ok && (alarm_cond ? under : over)) begin
            if (fault_cnt + 3'h1 >= fault_need) begin
               alarm_cond <= !alarm_cond;
               fault_cnt <= 3'h0;
               int_latch <= 1'b1; // set beats clear
            end else begin
               fault_cnt <= fault_cnt + 3'h1;
               if (int_clear) begin
                  int_latch <= 1'b0;
               end
            end
         end else begin
            if (conv_ok) begin
               fault_cnt <= 3'h0;
            end
            if (int_clear) begin
               int_latch <= 1'b0;
            end
         end
         // pin pulled low when active-low alarm fires or active-high one is idle
         alert_oe_o <= cfg[CFG_POL] ? !alert_act : alert_act;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_ro_write;
      state == ST_RX && !first && rx_done && ro_nack;
   endsequence
   sequence s_released_ack;
      !sda_oe_o [*2];
   endsequence
   AST_SDA_NEVER_HIGH:
      assert property (@(posedge clk_i) disable iff (!rst_n_i)
         sda_o == 1'b0 && (!sda_oe_o || state == ST_RX_ACK || state == ST_TX))
      else $error("sda driven high or pulled outside an own slot");
   AST_OE_AFTER_FALL:
      assert property (@(posedge clk_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> $past(scl_fall))
      else $error("sda pulled low without scl fall");
   AST_RO_NACK:
      assert property (@(posedge clk_i) disable iff (!rst_n_i) s_ro_write |=> s_released_ack)
      else $error("read-only write acknowledged");
   AST_ADDR_MISS:
      assert property (@(posedge clk_i) disable iff (!rst_n_i)
         rx_done && first && !addr_hit |=> state == ST_IDLE && !sda_oe_o)
      else $error("foreign address answered");
   AST_MODE_SELECT:
      assert property (@(posedge clk_i) disable iff (!rst_n_i)
         !cfg[CFG_COMPARATOR_INTERRUPT_SELECT] && !cfg[CFG_POL] && loaded ##1 !cfg[CFG_POL] |-> alert_oe_o == $past(alarm_cond))
      else $error("comparator mode does not follow condition");
   AST_POLARITY:
      assert property (@(posedge clk_i) disable iff (!rst_n_i) !alert_act && cfg[CFG_POL] |=> alert_oe_o)
      else $error("active-high alarm idle level wrong");
   AST_TRIP_ON_SAMPLE:
      assert property (@(posedge clk_i) disable iff (!rst_n_i) $changed(alarm_cond) |-> $past(conv_ok))
      else $error("alarm moved without a conversion");
   AST_SHUTDOWN_HOLD:
      assert property (@(posedge clk_i) disable iff (!rst_n_i) cfg[CFG_SD] && loaded |=> $stable(temp) && !conv_en_o)
      else $error("conversion active in shutdown");
   AST_RESTORE:
      assert property (@(posedge clk_i) disable iff (!rst_n_i)
         $rose(loaded) |-> cfg == $past(nv_config_i) && tlow == $past(nv_tlow_i))
      else $error("nonvolatile copy not restored");
endmodule

// >>> bench/i2c_host_model.sv
// two-wire host controller model that masters the sensor slave
`timescale 1ns/1ps
module i2c_host_model (
   // clock
   input wire logic clk_i,
   // bus wires
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // -----------------------------------
   // bit timing
   // -----------------------------------
   // each half bit well above the slave's 12-cycle filter delay
   localparam int HALF = 20;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hw();
      repeat (HALF) @(negedge clk_i);
   endtask
   // -----------------------------------
   // framing
   // -----------------------------------
   // data moves a few cycles after scl falls, so no false start or stop
   task automatic start();
      repeat (4) @(negedge clk_i);
      sda_o = 1'b1;
      hw();
      scl_o = 1'b1;
      hw();
      sda_o = 1'b0;
      hw();
      scl_o = 1'b0;
   endtask
   task automatic stop();
      repeat (4) @(negedge clk_i);
      sda_o = 1'b0;
      hw();
      scl_o = 1'b1;
      hw();
      sda_o = 1'b1;
      hw();
   endtask
   task automatic bit_out(input logic b);
      repeat (4) @(negedge clk_i);
      sda_o = b;
      hw();
      scl_o = 1'b1;
      hw();
      scl_o = 1'b0;
   endtask
   task automatic bit_in(output logic b);
      repeat (4) @(negedge clk_i);
      sda_o = 1'b1;
      hw();
      scl_o = 1'b1;
      hw();
      b = sda_i;
      scl_o = 1'b0;
   endtask
   // -----------------------------------
   // bytes
   // -----------------------------------
   task automatic wbyte(input logic [7:0] d, output logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(ack_n);
   endtask
   task automatic rbyte(output logic [7:0] d, input logic ack_n);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_in(b);
         d[i] = b;
      end
      bit_out(ack_n);
   endtask
endmodule

// >>> bench/temp_monitor_alert_bench.sv
// self-checking bench for the temperature monitor serial slave
`timescale 1ns/1ps
module temp_monitor_alert_bench
   import temp_monitor_pkg::*;
;
   // -----------------------------------
   // signals
   // -----------------------------------
   localparam logic [2:0] PINS = 3'h5;
   localparam logic [6:0] SENS = {SENSOR_ADDR_HI, PINS};
   localparam logic [6:0] EEP = {EEPROM_ADDR_HI, PINS};
   localparam int LIMIT = 80000;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic scl_line;
   logic host_sda;
   logic sda_line;
   logic sda_o;
   logic sda_oe_o;
   logic oe_q = 1'b0;
   logic alert_o;
   logic alert_oe_o;
   logic conv_en_o;
   logic [11:0] temp_sample_i = 12'h000;
   logic temp_valid_i = 1'b0;
   logic [7:0] nv_config_i = 8'h01;
   logic [15:0] nv_tlow_i = 16'h1900;
   logic [15:0] nv_thigh_i = 16'h3200;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   // open drain with pull-up: low if either party pulls
   assign sda_line = host_sda & ~sda_oe_o;
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   temp_monitor_alert temp_monitor_alert_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .scl_i(scl_line),
      .sda_i(sda_line),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .address_select_pins_i(PINS),
      .alert_o(alert_o),
      .alert_oe_o(alert_oe_o),
      .temp_sample_i(temp_sample_i),
      .temp_valid_i(temp_valid_i),
      .conv_en_o(conv_en_o),
      .nv_config_i(nv_config_i),
      .nv_tlow_i(nv_tlow_i),
      .nv_thigh_i(nv_thigh_i)
   );
   i2c_host_model i2c_host_model_inst (
      .clk_i(clk_i),
      .sda_i(sda_line),
      .scl_o(scl_line),
      .sda_o(host_sda)
   );
   // -----------------------------------
   // compare and report
   // -----------------------------------
   task automatic end_of_test();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // slave output moves only while scl low, and only ever pulls low
   always @(negedge clk_i) begin
      if (rst_n_i === 1'b1 && sda_oe_o !== oe_q && scl_line !== 1'b0) check_bit(scl_line, 1'b0);
      if (sda_oe_o === 1'b1) check_bit(sda_o, 1'b0);
      if (alert_oe_o === 1'b1) check_bit(alert_o, 1'b0);
      oe_q <= sda_oe_o;
   end
   // -----------------------------------
   // access tasks
   // -----------------------------------
   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic w_open(input logic [6:0] a, input logic exp);
      logic ack_n;
      i2c_host_model_inst.start();
      i2c_host_model_inst.wbyte({a, 1'b0}, ack_n);
      check_bit(ack_n, exp);
   endtask
   task automatic r_open(input logic [6:0] a, input logic exp);
      logic ack_n;
      i2c_host_model_inst.start();
      i2c_host_model_inst.wbyte({a, 1'b1}, ack_n);
      check_bit(ack_n, exp);
   endtask
   task automatic w_data(input logic [7:0] d, input logic exp);
      logic ack_n;
      i2c_host_model_inst.wbyte(d, ack_n);
      check_bit(ack_n, exp);
   endtask
   task automatic r_data(input logic [7:0] exp, input logic last);
      logic [7:0] d;
      i2c_host_model_inst.rbyte(d, last);
      check_byte(d, exp);
   endtask
   task automatic rd_reg(input logic [1:0] p, input logic [7:0] e0, input logic [7:0] e1, input int n);
      w_open(SENS, 1'b0);
      w_data({6'h00, p}, 1'b0);
      r_open(SENS, 1'b0);
      r_data(e0, n == 1);
      if (n == 2) r_data(e1, 1'b1);
      i2c_host_model_inst.stop();
   endtask
   task automatic wr_cfg(input logic [7:0] d);
      w_open(SENS, 1'b0);
      w_data({6'h00, PTR_CONFIG}, 1'b0);
      w_data(d, 1'b0);
      i2c_host_model_inst.stop();
   endtask
   task automatic pulse(input logic [11:0] s);
      temp_sample_i = s;
      temp_valid_i = 1'b1;
      @(negedge clk_i);
      temp_valid_i = 1'b0;
      repeat (8) @(negedge clk_i);
   endtask
   // -----------------------------------
   // tests
   // -----------------------------------
   initial begin
      do_reset();
      check_bit(conv_en_o, 1'b0);
      check_bit(alert_oe_o, 1'b0);
      rd_reg(PTR_THIGH, 8'h32, 8'h00, 2);
      rd_reg(PTR_CONFIG, 8'h01, 8'h00, 1);
      wr_cfg(8'h08);
      check_bit(conv_en_o, 1'b1);
      pulse(12'h7d0);
      w_open(SENS, 1'b0);
      w_data({6'h00, PTR_TEMP}, 1'b0);
      w_data(8'h00, 1'b1);
      i2c_host_model_inst.stop();
      rd_reg(PTR_TEMP, 8'h7d, 8'h00, 2);
      check_bit(alert_oe_o, 1'b0);
      pulse(12'h7d0);
      check_bit(alert_oe_o, 1'b1);
      pulse(12'hc90);
      rd_reg(PTR_TEMP, 8'hc9, 8'h00, 2);
      check_bit(alert_oe_o, 1'b1);
      pulse(12'hc90);
      check_bit(alert_oe_o, 1'b0);
      w_open({SENSOR_ADDR_HI, 3'h2}, 1'b1);
      i2c_host_model_inst.stop();
      // interrupt mode, one fault, active low as for a shared wire; a config read clears any stale latch
      wr_cfg(8'h02);
      rd_reg(PTR_CONFIG, 8'h02, 8'h00, 1);
      check_bit(alert_oe_o, 1'b0);
      r_open(ALERT_RESP_ADDR, 1'b1);
      i2c_host_model_inst.stop();
      pulse(12'h7d0);
      check_bit(alert_oe_o, 1'b1);
      r_open(ALERT_RESP_ADDR, 1'b0);
      r_data({SENSOR_ADDR_HI, PINS, 1'b0}, 1'b1);
      i2c_host_model_inst.stop();
      check_bit(alert_oe_o, 1'b0);
      pulse(12'h100);
      check_bit(alert_oe_o, 1'b1);
      wr_cfg(8'h04);
      check_bit(alert_oe_o, 1'b1);
      pulse(12'h7d0);
      check_bit(alert_oe_o, 1'b0);
      wr_cfg(8'h05);
      check_bit(conv_en_o, 1'b0);
      pulse(12'h100);
      check_bit(alert_oe_o, 1'b0);
      rd_reg(PTR_TEMP, 8'h7d, 8'h00, 2);
      w_open(EEP, 1'b0);
      w_data(8'h10, 1'b0);
      w_data(8'ha5, 1'b0);
      w_data(8'h5a, 1'b0);
      i2c_host_model_inst.stop();
      w_open(EEP, 1'b0);
      w_data(8'h10, 1'b0);
      r_open(EEP, 1'b0);
      r_data(8'ha5, 1'b0);
      r_data(8'h5a, 1'b1);
      i2c_host_model_inst.stop();
      // six faults in a row needed to clear, then four to trip
      wr_cfg(8'h18);
      repeat (5) pulse(12'h100);
      check_bit(alert_oe_o, 1'b1);
      pulse(12'h100);
      check_bit(alert_oe_o, 1'b0);
      wr_cfg(8'h10);
      repeat (3) pulse(12'h7d0);
      check_bit(alert_oe_o, 1'b0);
      pulse(12'h7d0);
      check_bit(alert_oe_o, 1'b1);
      // restart mid-run with a stored active-high alarm
      nv_config_i = 8'h04;
      do_reset();
      check_bit(conv_en_o, 1'b1);
      check_bit(alert_oe_o, 1'b1);
      rd_reg(PTR_TLOW, 8'h19, 8'h00, 2);
      end_of_test();
   end
endmodule
